// ===== hdl/chip_select_wait_state_unit.sv
// chip-select decode, wait-state and ready control, reset configuration
//----------------------------------------------------------------------
// Overview of operation
// [R1] boot fetch at FFFF0h, upper select, three waits
// [R2] reset held low at least 1ms
// [R3] capture AD at reset, hold, never drive
// [R4] selects assert for CPU and DMA cycles
// [R5] memory ranges plus 256-byte peripheral blocks
// [R6] control write enables decode, even as GENERAL_IO_PIN
// [R7] upper/lower select with non-multiplexed address
// [R8] bit 2 enables external ready
// [R9] bits 1-0 give 0 to 3 waits
// [R10] low peripherals add 5,7,9,15 via bit 3
// [R11] ready in wait one, then the remaining programmed waits
// [R12] three waits: seven cycles, else stretch
// [R13] async ready rising edge, synchronised
// [R14] internal block: zero waits, no ready
// [R15] address disable blocks AD address drive
// [R16] ready/wait stay active for GENERAL_IO_PIN pins
// [R17] fifth active; sixth/seventh off as address (the fifth block drives no select output here, only its waits apply)
// [R18] upper active at reset, 64K to 512K
// [R19] lower off at reset, width from aux
// [R20] clock outputs enabled by config 11-8
// [R21] interrupt leaves power save in T3
// [R22] reset stops bus, presets, clears watchdog
// [R23] selects low, released at cycle end
//----------------------------------------------------------------------
`timescale 1ns/1ps
`include "csw_consts.svh"
module chip_select_wait_state_unit (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // bus cycle request
    input wire logic cyc_req_i,
    input wire logic [19:0] cyc_addr_i,
    input wire logic cyc_io_i,
    input wire logic cyc_pcb_i,
    output logic cyc_busy_o,
    output logic cyc_done_o,
    output logic [19:0] bus_addr_o,
    output logic bus_width16_o,
    // multiplexed address/data bus
    input wire logic [15:0] ad_i,
    output logic ad_oe_n_o,
    // control register writes
    input wire logic upper_range_ctrl_wr_i,
    input wire logic lower_range_ctrl_wr_i,
    input wire logic mid_range_ctrl_wr_i,
    input wire logic periph_base_ctrl_wr_i,
    input wire logic mid_periph_size_ctrl_wr_i,
    input wire logic [15:0] ctrl_wdata_i,
    // configuration
    input wire logic [15:0] aux_config_i,
    input wire logic [15:0] sys_config_i,
    input wire logic [9:0] general_io_pin_mask_i,
    // ready inputs
    input wire logic async_ready_i,
    input wire logic sync_ready_i,
    // chip selects
    output logic upper_sel_n_o,
    output logic lower_sel_n_o,
    output logic [3:0] mid_sel_n_o,
    output logic [3:0] periph_select_low_group_n_o,
    output logic periph_select_sixth_n_o,
    output logic periph_select_seventh_n_o,
    output logic latched_addr_bit1_o,
    output logic latched_addr_bit2_o,
    // reset configuration and status
    output logic [15:0] reset_config_o,
    output logic cpu_run_o,
    output logic wdt_clear_o,
    // clocks and power save
    input wire logic psave_enter_i,
    input wire logic irq_i,
    output logic power_save_o,
    output logic clk_out_a_en_o,
    output logic clk_out_b_en_o,
    output logic clk_out_a_psave_o,
    output logic clk_out_b_psave_o
);
    import csw_pkg::*;

    //------------------------------------------------------------------
    // declarations
    //------------------------------------------------------------------
    logic [15:0] upper_ctrl_r, lower_ctrl_r, mid_ctrl_r, pbase_ctrl_r, mpsize_ctrl_r;
    logic lower_en_r, mid_en_r, pbase_en_r, mpsize_en_r;
    logic [15:0] ad_s1_r, ad_s2_r, reset_cfg_r;
    logic cap_done_r, booted_r;
    logic [3:0] boot_cnt_r;
    logic ardy_s1_r, ardy_s2_r, srdy_s1_r, srdy_s2_r, rdy;
    logic boot_start, start;
    logic [19:0] req_addr;
    logic req_io, req_pcb, mem;
    logic [3:0] up_bound, lo_mask;
    logic up_hit, lo_hit, mid_blk, mid_any, per_low_any, per_hi_any;
    logic [3:0] mid_hit;
    logic [6:0] per_hit, per_ok;
    logic [15:0] sel_ctrl;
    logic sel_wext, req_rdy_en, latch_mode, width16;
    wait_t req_waits;
    logic up_sel_r, lo_sel_r, sixth_r, seventh_r, da_r, rdy_en_q_r;
    logic [3:0] mid_sel_r, low_sel_r;
    logic [19:0] bus_addr_r;
    logic width16_r, la1_r, la2_r, psave_r;
    logic [3:0] clk_cfg_r;
    logic seq_busy, seq_t1, seq_t3, seq_first, seq_done;

    //------------------------------------------------------------------
    // reset configuration capture
    //------------------------------------------------------------------
    // free-running synchroniser keeps sampling while reset is low
    always_ff @(posedge clk_sys_i) begin
        ad_s1_r <= ad_i;
        ad_s2_r <= ad_s1_r;
    end

    // [R3] capture at release
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reset_cfg_r <= 16'h0000;
            cap_done_r <= 1'b0;
        end else if (!cap_done_r) begin
            reset_cfg_r <= ad_s2_r;
            cap_done_r <= 1'b1;
        end
    end

    //------------------------------------------------------------------
    // boot sequence
    //------------------------------------------------------------------
    // [R1] boot after internal interval
    assign boot_start = !booted_r && boot_cnt_r == 4'h0;

    // [R22] reset halts bus until boot
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            boot_cnt_r <= 4'(`CSW_BOOT_DLY_CYC);
            booted_r <= 1'b0;
        end else if (!booted_r) begin
            if (boot_cnt_r != 4'h0) boot_cnt_r <= boot_cnt_r - 4'h1;
            else booted_r <= 1'b1;
        end
    end

    //------------------------------------------------------------------
    // control registers
    //------------------------------------------------------------------
    // [R6] write enables the decode
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            upper_ctrl_r <= `CSW_UPPER_RST;
            lower_ctrl_r <= `CSW_CTRL_RST;
            mid_ctrl_r <= `CSW_CTRL_RST;
            pbase_ctrl_r <= `CSW_CTRL_RST;
            mpsize_ctrl_r <= `CSW_CTRL_RST;
        end else begin
            if (upper_range_ctrl_wr_i) upper_ctrl_r <= ctrl_wdata_i;
            if (lower_range_ctrl_wr_i) lower_ctrl_r <= ctrl_wdata_i;
            if (mid_range_ctrl_wr_i) mid_ctrl_r <= ctrl_wdata_i;
            if (periph_base_ctrl_wr_i) pbase_ctrl_r <= ctrl_wdata_i;
            if (mid_periph_size_ctrl_wr_i) mpsize_ctrl_r <= ctrl_wdata_i;
        end
    end

    // [R19] lower select off until written
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            lower_en_r <= 1'b0;
            mid_en_r <= 1'b0;
            pbase_en_r <= 1'b0;
            mpsize_en_r <= 1'b0;
        end else begin
            lower_en_r <= lower_en_r | lower_range_ctrl_wr_i;
            mid_en_r <= mid_en_r | mid_range_ctrl_wr_i;
            pbase_en_r <= pbase_en_r | periph_base_ctrl_wr_i;
            mpsize_en_r <= mpsize_en_r | mid_periph_size_ctrl_wr_i;
        end
    end

    //------------------------------------------------------------------
    // ready synchronisers
    //------------------------------------------------------------------
    // [R13] two-stage ready sampling
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ardy_s1_r <= 1'b0;
            ardy_s2_r <= 1'b0;
            srdy_s1_r <= 1'b0;
            srdy_s2_r <= 1'b0;
        end else begin
            ardy_s1_r <= async_ready_i;
            ardy_s2_r <= ardy_s1_r;
            srdy_s1_r <= sync_ready_i;
            srdy_s2_r <= srdy_s1_r;
        end
    end

    assign rdy = ardy_s2_r | srdy_s2_r;

    //------------------------------------------------------------------
    // address decode
    //------------------------------------------------------------------
    // [R4] one request path for CPU and DMA cycles
    assign start = boot_start || (booted_r && cyc_req_i && !seq_busy);
    assign req_addr = booted_r ? cyc_addr_i : `CSW_BOOT_ADDR;
    assign req_io = booted_r && cyc_io_i;
    assign req_pcb = booted_r && cyc_pcb_i;
    assign mem = !req_io && !req_pcb;

    // [R18] upper range 64K to 512K below top
    assign up_bound = 4'(4'hF << upper_ctrl_r[`CSW_F_SIZE]);
    assign up_hit = mem && (req_addr[19:16] & up_bound) == up_bound;
    assign lo_mask = 4'(4'hF << lower_ctrl_r[`CSW_F_SIZE]);
    assign lo_hit = mem && lower_en_r && (req_addr[19:16] & lo_mask) == 4'h0;

    // [R5] midrange block and peripheral blocks
    assign mid_blk = mem && mid_en_r && req_addr[19:13] == mid_ctrl_r[`CSW_F_MBASE];
    assign mid_hit = mid_blk ? 4'(4'h1 << req_addr[12:11]) : 4'h0;
    assign mid_any = |mid_hit;

    periph_decoder u_periph (
        .addr_i(req_addr),
        .io_i(req_io),
        .en_i(pbase_en_r && mpsize_en_r && !req_pcb),
        .io_space_i(mpsize_ctrl_r[`CSW_B_PIO_SPACE]),
        .base_i(pbase_ctrl_r[`CSW_F_PBASE]),
        .hit_o(per_hit)
    );

    // [R17] sixth and seventh drop out in address mode
    assign latch_mode = mpsize_ctrl_r[`CSW_B_LATCH];
    assign per_ok = per_hit & {~latch_mode, ~latch_mode, 5'b1_1111};
    assign per_low_any = |per_ok[4:0];
    assign per_hi_any = |per_ok[6:5];

    //------------------------------------------------------------------
    // wait and ready selection
    //------------------------------------------------------------------
    assign sel_ctrl = up_hit ? upper_ctrl_r :
                      lo_hit ? lower_ctrl_r :
                      mid_any ? mid_ctrl_r :
                      per_low_any ? pbase_ctrl_r :
                      per_hi_any ? mpsize_ctrl_r : 16'h0000;

    // [R10] extended codes only for the low group and fifth
    assign sel_wext = !up_hit && !lo_hit && !mid_any && per_low_any;

    // [R9] two-bit wait field
    // [R14] internal block: no waits, no ready
    assign req_waits = req_pcb ? 4'h0
                     : wait_decode(sel_wext && sel_ctrl[`CSW_B_WEXT], sel_ctrl[`CSW_F_WAIT]);

    // [R8] external ready enable
    assign req_rdy_en = !req_pcb && sel_ctrl[`CSW_B_RDY];

    // [R19] lower width from aux configuration
    assign width16 = lo_hit ? aux_config_i[`CSW_B_AUX_LW16]
                   : up_hit ? 1'b1 : aux_config_i[`CSW_B_AUX_OW16];

    //------------------------------------------------------------------
    // bus cycle sequencer
    //------------------------------------------------------------------
    // [R11] ready in first wait, then remaining waits
    wait_sequencer u_seq (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i),
        .start_i(start),
        .waits_i(req_waits),
        .rdy_en_i(req_rdy_en),
        .rdy_i(rdy),
        .busy_o(seq_busy),
        .t1_o(seq_t1),
        .t3_o(seq_t3),
        .first_wait_o(seq_first),
        .done_o(seq_done)
    );

    //------------------------------------------------------------------
    // select registers
    //------------------------------------------------------------------
    // [R23] load at start, release after T4
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            up_sel_r <= 1'b0;
            lo_sel_r <= 1'b0;
            mid_sel_r <= 4'h0;
            low_sel_r <= 4'h0;
            sixth_r <= 1'b0;
            seventh_r <= 1'b0;
            da_r <= 1'b0;
        end else if (start) begin
            up_sel_r <= up_hit;
            lo_sel_r <= lo_hit;
            mid_sel_r <= mid_hit;
            low_sel_r <= per_ok[3:0];
            sixth_r <= per_ok[5];
            seventh_r <= per_ok[6];
            da_r <= (up_hit && upper_ctrl_r[`CSW_B_DA]) || (lo_hit && lower_ctrl_r[`CSW_B_DA]);
        end else if (seq_done) begin
            up_sel_r <= 1'b0;
            lo_sel_r <= 1'b0;
            mid_sel_r <= 4'h0;
            low_sel_r <= 4'h0;
            sixth_r <= 1'b0;
            seventh_r <= 1'b0;
            da_r <= 1'b0;
        end
    end

    // [R7] address and width latched with the selects
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bus_addr_r <= 20'h0_0000;
            width16_r <= 1'b0;
            la1_r <= 1'b0;
            la2_r <= 1'b0;
            rdy_en_q_r <= 1'b0;
        end else if (start) begin
            bus_addr_r <= req_addr;
            width16_r <= width16;
            la1_r <= latch_mode && req_addr[1];
            la2_r <= latch_mode && req_addr[2];
            rdy_en_q_r <= req_rdy_en;
        end
    end

    //------------------------------------------------------------------
    // clocks and power save
    //------------------------------------------------------------------
    // [R21] interrupt exit in T3; entry takes priority
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            psave_r <= 1'b0;
            clk_cfg_r <= 4'h0;
        end else begin
            if (irq_i && seq_t3) psave_r <= 1'b0;
            if (psave_enter_i) psave_r <= 1'b1;
            // [R20] clock output enables
            clk_cfg_r <= sys_config_i[`CSW_B_CLKB_PS:`CSW_B_CLKA_EN];
        end
    end

    //------------------------------------------------------------------
    // outputs
    //------------------------------------------------------------------
    // [R16] GENERAL_IO_PIN pins stay high, waits still apply
    assign upper_sel_n_o = !up_sel_r;
    assign lower_sel_n_o = !lo_sel_r;
    assign mid_sel_n_o = ~(mid_sel_r & ~general_io_pin_mask_i[3:0]);
    assign periph_select_low_group_n_o = ~(low_sel_r & ~general_io_pin_mask_i[7:4]);
    assign periph_select_sixth_n_o = !(sixth_r && !general_io_pin_mask_i[8]);
    assign periph_select_seventh_n_o = !(seventh_r && !general_io_pin_mask_i[9]);
    assign latched_addr_bit1_o = la1_r;
    assign latched_addr_bit2_o = la2_r;

    // [R15] no address drive with disable set
    assign ad_oe_n_o = !(seq_t1 && !da_r);

    assign cyc_busy_o = seq_busy || !booted_r;
    assign cyc_done_o = seq_done;
    assign bus_addr_o = bus_addr_r;
    assign bus_width16_o = width16_r;
    assign reset_config_o = reset_cfg_r;
    assign cpu_run_o = booted_r;
    // [R22] watchdog held clear until boot
    assign wdt_clear_o = !booted_r;
    assign power_save_o = psave_r;
    assign clk_out_a_en_o = clk_cfg_r[0];
    assign clk_out_b_en_o = clk_cfg_r[1];
    assign clk_out_a_psave_o = clk_cfg_r[2];
    assign clk_out_b_psave_o = clk_cfg_r[3];

    //------------------------------------------------------------------
    // assertions
    //------------------------------------------------------------------
    property p_boot_fetch;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        boot_start |=> (bus_addr_o == `CSW_BOOT_ADDR && !upper_sel_n_o);
    endproperty
    a_boot_fetch: assert property (p_boot_fetch) else $error("boot fetch wrong"); // [R1]

    property p_boot_waits;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        boot_start |-> (req_waits == 4'h3 && req_rdy_en);
    endproperty
    a_boot_waits: assert property (p_boot_waits) else $error("boot waits wrong"); // [R1]

    property p_cfg_hold;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        (cap_done_r && $past(cap_done_r)) |-> $stable(reset_config_o);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("reset config changed"); // [R3]

    property p_no_drive;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        !booted_r |-> ad_oe_n_o;
    endproperty
    a_no_drive: assert property (p_no_drive) else $error("bus driven before boot"); // [R3]

    property p_da_block;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        (start && up_hit && upper_ctrl_r[`CSW_B_DA]) |=> ad_oe_n_o;
    endproperty
    a_da_block: assert property (p_da_block) else $error("address driven with disable"); // [R15]

    property p_pcb_zero;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        (start && req_pcb) |=> !cyc_done_o ##3 cyc_done_o;
    endproperty
    a_pcb_zero: assert property (p_pcb_zero) else $error("internal access not 4 cycles"); // [R14]

    property p_seven;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        (start && req_waits == 4'h3 && !req_rdy_en) |=> (!cyc_done_o) [*6] ##1 cyc_done_o;
    endproperty
    a_seven: assert property (p_seven) else $error("three-wait cycle not seven"); // [R12]

    property p_stretch;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        (seq_first && rdy_en_q_r && !rdy) |=> (seq_first && !cyc_done_o);
    endproperty
    a_stretch: assert property (p_stretch) else $error("no stretch without ready"); // [R11]

    property p_idle_high;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        (!seq_busy && !cyc_done_o) |-> (upper_sel_n_o && lower_sel_n_o && &mid_sel_n_o);
    endproperty
    a_idle_high: assert property (p_idle_high) else $error("select low when idle"); // [R23]

    property p_psave_exit;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        (power_save_o && irq_i && seq_t3 && !psave_enter_i) |=> !power_save_o;
    endproperty
    a_psave_exit: assert property (p_psave_exit) else $error("power save not left"); // [R21]
endmodule : chip_select_wait_state_unit

// ===== hdl/csw_consts.svh
// constants for the chip-select and wait-state unit
`ifndef CSW_CONSTS_SVH
`define CSW_CONSTS_SVH
`define CSW_F_WAIT 1:0
`define CSW_B_RDY 2
`define CSW_B_WEXT 3
`define CSW_B_DA 7
`define CSW_F_SIZE 13:12
`define CSW_F_MBASE 15:9
`define CSW_F_PBASE 15:7
`define CSW_B_PIO_SPACE 6
`define CSW_B_LATCH 7
`define CSW_B_AUX_LW16 0
`define CSW_B_AUX_OW16 1
`define CSW_B_CLKA_EN 8
`define CSW_B_CLKB_EN 9
`define CSW_B_CLKA_PS 10
`define CSW_B_CLKB_PS 11
`define CSW_UPPER_RST 16'h0007
`define CSW_CTRL_RST 16'h0000
`define CSW_BOOT_ADDR 20'hF_FFF0
`define CSW_WAIT_X0 4'h5
`define CSW_WAIT_X1 4'h7
`define CSW_WAIT_X2 4'h9
`define CSW_WAIT_X3 4'hF
`define CSW_CLK_NS 25
`define CSW_BOOT_DLY_NS 200
`define CSW_BOOT_DLY_CYC ((`CSW_BOOT_DLY_NS + `CSW_CLK_NS - 1) / `CSW_CLK_NS)
`endif

// ===== hdl/csw_pkg.sv
// types and wait decoding for the chip-select and wait-state unit
package csw_pkg;
`include "csw_consts.svh"
    typedef enum logic [2:0] {ST_IDLE, ST_T1, ST_T2, ST_T3, ST_TW, ST_T4} bus_state_e;
    typedef logic [3:0] wait_t;

    function automatic wait_t wait_decode(input logic ext, input logic [1:0] lo);
        wait_t w;
        w = {2'b00, lo};
        if (ext) begin
            unique case (lo)
                2'b00: w = `CSW_WAIT_X0;
                2'b01: w = `CSW_WAIT_X1;
                2'b10: w = `CSW_WAIT_X2;
                2'b11: w = `CSW_WAIT_X3;
            endcase
        end
        return w;
    endfunction : wait_decode
endpackage : csw_pkg

// ===== hdl/periph_decoder.sv
// seven 256-byte peripheral blocks above one base
`timescale 1ns/1ps
module periph_decoder (
    // cycle address
    input wire logic [19:0] addr_i,
    input wire logic io_i,
    // configuration
    input wire logic en_i,
    input wire logic io_space_i,
    input wire logic [8:0] base_i,
    // hits
    output logic [6:0] hit_o
);
    logic blk;

    assign blk = en_i && (io_i == io_space_i) && (addr_i[19:11] == base_i);

    for (genvar i = 0; i < 7; i++) begin : g_blk
        assign hit_o[i] = blk && (addr_i[10:8] == 3'(i));
    end
endmodule : periph_decoder

// ===== hdl/wait_sequencer.sv
// bus cycle state sequence with wait states and ready
`timescale 1ns/1ps
module wait_sequencer (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // cycle request
    input wire logic start_i,
    input csw_pkg::wait_t waits_i,
    input wire logic rdy_en_i,
    input wire logic rdy_i,
    // cycle state
    output logic busy_o,
    output logic t1_o,
    output logic t3_o,
    output logic first_wait_o,
    output logic done_o
);
    import csw_pkg::*;

    bus_state_e state_r, state_nxt;
    wait_t wcnt_r, wcnt_nxt, wlen_r;
    logic first_r, first_nxt, rdy_en_r, accept, hold;

    assign accept = start_i && (state_r == ST_IDLE || state_r == ST_T4);
    // first wait stretches until ready
    assign hold = first_r && rdy_en_r && !rdy_i;

    always_comb begin
        state_nxt = state_r;
        wcnt_nxt = wcnt_r;
        first_nxt = first_r;
        unique case (state_r)
            ST_IDLE: if (start_i) state_nxt = ST_T1;
            ST_T1: state_nxt = ST_T2;
            ST_T2: state_nxt = ST_T3;
            ST_T3: begin
                if (wlen_r != 4'h0) begin
                    state_nxt = ST_TW;
                    wcnt_nxt = wlen_r - 4'h1;
                    first_nxt = 1'b1;
                end else if (!rdy_en_r || rdy_i) begin
                    state_nxt = ST_T4;
                end
            end
            ST_TW: begin
                if (!hold) begin
                    first_nxt = 1'b0;
                    if (wcnt_r == 4'h0) state_nxt = ST_T4;
                    else wcnt_nxt = wcnt_r - 4'h1;
                end
            end
            ST_T4: state_nxt = start_i ? ST_T1 : ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_r <= ST_IDLE;
            wcnt_r <= 4'h0;
            first_r <= 1'b0;
            wlen_r <= 4'h0;
            rdy_en_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            wcnt_r <= wcnt_nxt;
            first_r <= first_nxt;
            if (accept) wlen_r <= waits_i;
            if (accept) rdy_en_r <= rdy_en_i;
        end
    end

    assign busy_o = !(state_r == ST_IDLE || state_r == ST_T4);
    assign t1_o = state_r == ST_T1;
    assign t3_o = state_r == ST_T3;
    assign first_wait_o = state_r == ST_TW && first_r;
    assign done_o = state_r == ST_T4;
endmodule : wait_sequencer

// ===== tb/ready_model.sv
// external memory on the upper range, answering ready after a delay
`timescale 1ns/1ps
module ready_model (
    // bus side
    input wire logic clk_sys_i,
    input wire logic sel_n_i,
    input wire logic [3:0] delay_i,
    output logic ready_o
);
    logic [3:0] cnt_r;
    always_ff @(posedge clk_sys_i) begin
        if (sel_n_i) begin
            cnt_r <= 4'h0;
        end else if (cnt_r != 4'hF) begin
            cnt_r <= cnt_r + 4'h1;
        end
    end
    // ready only while selected, low once released
    assign ready_o = !sel_n_i && (cnt_r >= delay_i);
endmodule : ready_model

// ===== tb/tb_top.sv
// self-checking bench for the chip-select and wait-state unit
`timescale 1ns/1ps
module tb_top;
    import csw_pkg::*;
    logic clk_sys_i, arst_n_i, cyc_req_i, cyc_io_i, cyc_pcb_i, cyc_busy_o, cyc_done_o;
    logic bus_width16_o, ad_oe_n_o, async_ready_i, sync_ready_i, upper_sel_n_o, lower_sel_n_o;
    logic upper_range_ctrl_wr_i, lower_range_ctrl_wr_i, mid_range_ctrl_wr_i;
    logic periph_base_ctrl_wr_i, mid_periph_size_ctrl_wr_i, psave_enter_i, irq_i;
    logic periph_select_sixth_n_o, periph_select_seventh_n_o, latched_addr_bit1_o;
    logic latched_addr_bit2_o, cpu_run_o, wdt_clear_o, power_save_o, wid;
    logic clk_out_a_en_o, clk_out_b_en_o, clk_out_a_psave_o, clk_out_b_psave_o;
    logic [19:0] cyc_addr_i, bus_addr_o, adr;
    logic [15:0] ad_i, ctrl_wdata_i, aux_config_i, sys_config_i, reset_config_o;
    logic [9:0] general_io_pin_mask_i;
    logic [3:0] mid_sel_n_o, periph_select_low_group_n_o, dly;
    int bad_count = 0;
    int n_compared = 0;
    int n_up, n_lo, n_oe;
    chip_select_wait_state_unit uut (.*);
    ready_model ready_mem (.clk_sys_i(clk_sys_i), .sel_n_i(upper_sel_n_o), .delay_i(dly),
        .ready_o(async_ready_i));
    always #12.5 clk_sys_i = ~clk_sys_i;
    //--------------------------------
    // helpers
    //--------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test
    // count select-low cycles from T1 through T4
    task automatic watch();
        n_up = 0;
        n_lo = 0;
        n_oe = 0;
        for (int i = 0; i < 60; i++) begin
            n_up += int'(upper_sel_n_o === 1'b0);
            n_lo += int'(lower_sel_n_o === 1'b0);
            n_oe += int'(ad_oe_n_o === 1'b0);
            adr = bus_addr_o;
            wid = bus_width16_o;
            if (cyc_done_o === 1'b1) break;
            @(negedge clk_sys_i);
        end
        @(negedge clk_sys_i);
    endtask : watch
    task automatic cyc(input logic [19:0] a);
        cyc_addr_i = a;
        cyc_req_i = 1'b1;
        @(negedge clk_sys_i);
        cyc_req_i = 1'b0;
        watch();
    endtask : cyc
    task automatic wr_lower(input logic [15:0] d);
        ctrl_wdata_i = d;
        lower_range_ctrl_wr_i = 1'b1;
        @(negedge clk_sys_i);
        lower_range_ctrl_wr_i = 1'b0;
    endtask : wr_lower
    //--------------------------------
    // scenarios
    //--------------------------------
    task automatic t_boot();
        for (int i = 0; i < 20 && upper_sel_n_o !== 1'b0; i++) @(negedge clk_sys_i);
        watch();
        chk(n_up, 7);
        chk(adr, 20'hF_FFF0);
        chk(reset_config_o, 16'hA5C3);
        chk({cpu_run_o, wdt_clear_o}, 2'h2);
        chk({mid_sel_n_o, periph_select_low_group_n_o}, 8'hFF);
        chk({clk_out_b_psave_o, clk_out_a_psave_o, clk_out_b_en_o, clk_out_a_en_o}, 4'hA);
        $display("boot done");
    endtask : t_boot
    task automatic t_lower();
        cyc(20'h0_0100);
        chk(n_lo, 0);
        for (int w = 0; w < 4; w++) begin
            wr_lower(16'(w));
            cyc(20'h0_0100);
            chk(n_lo, 4 + w);
            chk(n_up, 0);
            chk(n_oe, 1);
            chk(wid, 1'b1);
        end
        wr_lower(16'h0080);
        cyc(20'h0_0100);
        chk(n_oe, 0);
        chk(n_lo, 4);
        $display("lower done");
    endtask : t_lower
    task automatic t_slow();
        dly = 4'h8;
        cyc(20'hF_8000);
        chk(n_up, 14);
        $display("slow ready done");
    endtask : t_slow
    initial begin
        {clk_sys_i, arst_n_i, cyc_req_i, cyc_io_i, cyc_pcb_i, sync_ready_i, irq_i} = 7'h00;
        {upper_range_ctrl_wr_i, lower_range_ctrl_wr_i, mid_range_ctrl_wr_i} = 3'h0;
        {periph_base_ctrl_wr_i, mid_periph_size_ctrl_wr_i, psave_enter_i} = 3'h0;
        {cyc_addr_i, ctrl_wdata_i, general_io_pin_mask_i, dly} = 50'h0;
        ad_i = 16'hA5C3;
        aux_config_i = 16'h0001;
        sys_config_i = 16'h0A00;
        repeat (8) @(negedge clk_sys_i);
        chk({ad_oe_n_o, upper_sel_n_o}, 2'h3);
        arst_n_i = 1'b1;
        t_boot();
        t_lower();
        t_slow();
        stop_test();
    end
    initial begin
        #(25 * 3000);
        bad_count++;
        stop_test();
    end
endmodule : tb_top
